// ==== etfb_byte_sel.sv ====
// picks the frame byte that belongs at a given offset
`timescale 1ns/1ps
module etfb_byte_sel
	import etfb_pkg::*;
(
	input wire logic [5:0] idx_i,
	input wire logic [7:0] sum_i,
	input wire logic [7:0] frame_id_i,
	input wire logic [63:0] dest64_i,
	input wire logic [15:0] dest16_i,
	input wire logic [15:0] cluster_i,
	input wire logic [7:0] radius_i,
	input wire logic [7:0] seq_i,
	input wire logic [63:0] param_i,
	input wire logic [3:0] nparam_i,
	output logic [7:0] byte_o
);
	logic [5:0] back;
	logic [5:0] pofs;
	logic [5:0] csum_idx;

	always_comb begin
		back = OFS_DEST64_LSB - idx_i;
		pofs = idx_i - OFS_PARAM;
		csum_idx = OFS_PARAM + {2'h0, nparam_i};
		byte_o = 8'h00;
		if (idx_i == 6'h00) begin
			byte_o = START_DELIM;
		end else if (idx_i == OFS_LEN_MSB) begin
			byte_o = 8'h00;
		end else if (idx_i == OFS_LEN_LSB) begin
			byte_o = LEN_FIXED + {4'h0, nparam_i};
		end else if (idx_i == OFS_TYPE) begin
			byte_o = FRAME_TYPE_EXPLICIT;
		end else if (idx_i == OFS_FRAME_ID) begin
			byte_o = frame_id_i;
		end else if (idx_i <= OFS_DEST64_LSB) begin
			byte_o = 8'(dest64_i >> {back[2:0], 3'h0});
		end else if (idx_i == OFS_DEST16_MSB) begin
			byte_o = dest16_i[15:8];
		end else if (idx_i == OFS_DEST16_LSB) begin
			byte_o = dest16_i[7:0];
		end else if (idx_i == OFS_SRC_EP || idx_i == OFS_DST_EP) begin
			byte_o = MGMT_ENDPOINT;
		end else if (idx_i == OFS_CLUSTER_MSB) begin
			byte_o = cluster_i[15:8];
		end else if (idx_i == OFS_CLUSTER_LSB) begin
			byte_o = cluster_i[7:0];
		end else if (idx_i == OFS_PROFILE_MSB || idx_i == OFS_PROFILE_LSB) begin
			byte_o = MGMT_PROFILE_BYTE;
		end else if (idx_i == OFS_RADIUS) begin
			byte_o = radius_i;
		end else if (idx_i == OFS_OPTIONS) begin
			byte_o = TX_OPTIONS_MGMT;
		end else if (idx_i == OFS_SEQ) begin
			byte_o = seq_i;
		end else if (idx_i < csum_idx) begin
			byte_o = 8'(param_i >> {pofs[2:0], 3'h0});
		end else begin
			byte_o = CSUM_BASE - sum_i;
		end
	end
endmodule

// ==== etfb_ctrl.sv ====
// host-side builder of explicit transmit frames for management commands
`timescale 1ns/1ps
module etfb_ctrl
	import etfb_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	output logic RX_FORMAT_SEL
);
	////////////////////////////////////////////////////////////////
	// registers
	etfb_state_t state_reg;
	logic [2:0] ctrl_reg;
	logic [31:0] dest_hi_reg;
	logic [31:0] dest_lo_reg;
	logic [15:0] dest16_reg;
	logic [31:0] cmd_reg;
	logic [31:0] param_lo_reg;
	logic [31:0] param_hi_reg;
	logic [3:0] plen_reg;
	logic done_reg;
	logic err_reg;
	logic expect_status_reg;
	logic [7:0] count_reg;
	logic [31:0] prdata_reg;
	logic [7:0] tx_data_reg;
	logic tx_valid_reg;
	logic [5:0] idx_reg;
	logic [7:0] sum_reg;

	logic busy;
	logic wr;
	logic rd_setup;
	logic mapped;
	logic field_reg;
	logic refuse;
	logic start_req;
	logic start_ok;
	logic [16:0] cl_lookup;
	logic [3:0] nparam;
	logic [63:0] dest64_eff;
	logic [15:0] dest16_eff;
	logic [5:0] last_idx;
	logic accept;
	logic [7:0] sum_next;
	logic [5:0] idx_next;
	logic [7:0] next_byte;
	logic [7:0] status_frame_id;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////
	// apb decode, zero wait states
	assign busy = (state_reg == ETFB_SEND);
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= REG_STATUS);
	assign field_reg = PADDR != REG_STATUS;
	assign refuse = !mapped || (PWRITE && busy && field_reg);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && refuse;
	assign PRDATA = prdata_reg;
	assign RX_FORMAT_SEL = ctrl_reg[2];

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (PADDR)
			REG_CTRL: rd_mux = {29'h0, ctrl_reg};
			REG_DEST_HI: rd_mux = dest_hi_reg;
			REG_DEST_LO: rd_mux = dest_lo_reg;
			REG_DEST16: rd_mux = {16'h0, dest16_reg};
			REG_CMD: rd_mux = cmd_reg;
			REG_PARAM_LO: rd_mux = param_lo_reg;
			REG_PARAM_HI: rd_mux = param_hi_reg;
			REG_PLEN: rd_mux = {28'h0, plen_reg};
			REG_STATUS: rd_mux = {16'h0, count_reg, 4'h0, expect_status_reg, err_reg, done_reg, busy};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			prdata_reg <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctrl_reg <= CTRL_RESET;
			dest_hi_reg <= 32'h00000000;
			dest_lo_reg <= 32'h00000000;
			dest16_reg <= DEST16_UNKNOWN;
			cmd_reg <= CMD_RESET;
			param_lo_reg <= 32'h00000000;
			param_hi_reg <= 32'h00000000;
			plen_reg <= 4'h0;
		end else if (wr && !refuse) begin
			unique case (PADDR)
				REG_CTRL: ctrl_reg <= PWDATA[3:1];
				REG_DEST_HI: dest_hi_reg <= PWDATA;
				REG_DEST_LO: dest_lo_reg <= PWDATA;
				REG_DEST16: dest16_reg <= PWDATA[15:0];
				REG_CMD: cmd_reg <= PWDATA;
				REG_PARAM_LO: param_lo_reg <= PWDATA;
				REG_PARAM_HI: param_hi_reg <= PWDATA;
				REG_PLEN: plen_reg <= PWDATA[3:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// frame fields
	assign cl_lookup = etfb_cluster(cmd_reg[3:0]);
	assign nparam = (cmd_reg[3:0] == CMD_ACTIVE_EP) ? ACTIVE_EP_PARAM_BYTES : plen_reg;
	assign last_idx = OFS_PARAM + {2'h0, nparam};
	assign status_frame_id = cmd_reg[15:8];

	always_comb begin
		dest64_eff = {dest_hi_reg, dest_lo_reg};
		dest16_eff = dest16_reg;
		unique case (ctrl_reg[1:0])
			ADDR_COORD: dest64_eff = DEST64_COORD;
			ADDR_BCAST: begin
				dest64_eff = DEST64_BCAST;
				dest16_eff = DEST16_UNKNOWN;
			end
			default: ;
		endcase
	end

	assign start_req = wr && !refuse && (PADDR == REG_CTRL) && PWDATA[0] && !busy;
	assign start_ok = start_req && cl_lookup[16] && (plen_reg <= MAX_PARAM_BYTES);
	assign accept = tx_valid_reg && TX_READY;
	assign sum_next = (idx_reg >= OFS_TYPE) ? sum_reg + tx_data_reg : sum_reg;
	assign idx_next = idx_reg + 6'h01;

	etfb_byte_sel u_sel (
		.idx_i(idx_next),
		.sum_i(sum_next),
		.frame_id_i(status_frame_id),
		.dest64_i(dest64_eff),
		.dest16_i(dest16_eff),
		.cluster_i(cl_lookup[15:0]),
		.radius_i(cmd_reg[23:16]),
		.seq_i(cmd_reg[31:24]),
		.param_i({param_hi_reg, param_lo_reg}),
		.nparam_i(nparam),
		.byte_o(next_byte)
	);

	////////////////////////////////////////////////////////////////
	// serial byte stream
	assign TX_DATA = tx_data_reg;
	assign TX_VALID = tx_valid_reg;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_reg <= ETFB_IDLE;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			idx_reg <= 6'h00;
			sum_reg <= 8'h00;
		end else begin
			unique case (state_reg)
				ETFB_IDLE: begin
					if (start_ok) begin
						state_reg <= ETFB_SEND;
						tx_valid_reg <= 1'b1;
						tx_data_reg <= START_DELIM;
						idx_reg <= 6'h00;
						sum_reg <= 8'h00;
					end
				end
				ETFB_SEND: begin
					if (accept) begin
						if (idx_reg == last_idx) begin
							state_reg <= ETFB_IDLE;
							tx_valid_reg <= 1'b0;
						end else begin
							idx_reg <= idx_next;
							tx_data_reg <= next_byte;
							sum_reg <= sum_next;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// status flags, set wins over write-one-to-clear
	logic frame_end;
	// last_idx is the checksum offset, so the frame ends once it is taken
	assign frame_end = accept && (idx_reg == last_idx);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			expect_status_reg <= 1'b0;
			count_reg <= 8'h00;
		end else begin
			if (frame_end) begin
				done_reg <= 1'b1;
				count_reg <= count_reg + 8'h01;
			end else if (wr && PADDR == REG_STATUS && PWDATA[1]) begin
				done_reg <= 1'b0;
			end
			if (start_req && !start_ok) begin
				err_reg <= 1'b1;
			end else if (wr && PADDR == REG_STATUS && PWDATA[2]) begin
				err_reg <= 1'b0;
			end
			if (start_ok) begin
				expect_status_reg <= (status_frame_id != 8'h00);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	sequence s_accept_at(logic [5:0] ofs);
		tx_valid_reg && idx_reg == ofs;
	endsequence

	a_start_delim: assert property (@(posedge CLK) disable iff (RESET)
		start_ok |=> tx_valid_reg && tx_data_reg == START_DELIM && idx_reg == 6'h00)
		else $error("frame did not open with the start delimiter");
	a_type_byte: assert property (@(posedge CLK) disable iff (RESET)
		s_accept_at(OFS_TYPE) |-> tx_data_reg == FRAME_TYPE_EXPLICIT)
		else $error("frame type byte wrong");
	a_len_byte: assert property (@(posedge CLK) disable iff (RESET)
		s_accept_at(OFS_LEN_LSB) |-> tx_data_reg == 8'(last_idx - OFS_TYPE))
		else $error("length byte wrong");
	a_endpoint_zero: assert property (@(posedge CLK) disable iff (RESET)
		(s_accept_at(OFS_SRC_EP) or s_accept_at(OFS_DST_EP)) |-> tx_data_reg == 8'h00)
		else $error("endpoint byte not zero");
	a_profile_opts: assert property (@(posedge CLK) disable iff (RESET)
		(s_accept_at(OFS_PROFILE_LSB) or s_accept_at(OFS_OPTIONS)) |-> tx_data_reg == 8'h00)
		else $error("profile or options byte not zero");
	a_bcast_short: assert property (@(posedge CLK) disable iff (RESET)
		s_accept_at(OFS_DEST16_MSB) ##0 (ctrl_reg[1:0] == ADDR_BCAST && TX_READY)
		|=> tx_data_reg == 8'hfe && idx_reg == OFS_DEST16_LSB)
		else $error("broadcast short address wrong");
	a_param_lsb: assert property (@(posedge CLK) disable iff (RESET)
		s_accept_at(OFS_PARAM) ##0 (nparam != 4'h0) |-> tx_data_reg == param_lo_reg[7:0])
		else $error("first parameter byte is not the low byte");
	a_hold_byte: assert property (@(posedge CLK) disable iff (RESET)
		tx_valid_reg && !TX_READY |=> tx_valid_reg && $stable(tx_data_reg) && $stable(idx_reg))
		else $error("byte changed before it was taken");
	a_checksum: assert property (@(posedge CLK) disable iff (RESET)
		s_accept_at(last_idx) |-> 8'(sum_reg + tx_data_reg) == 8'hff)
		else $error("checksum does not balance");
	a_frame_ends: assert property (@(posedge CLK) disable iff (RESET)
		frame_end |=> !tx_valid_reg && done_reg && !busy)
		else $error("frame did not end after checksum");
	a_rx_format: assert property (@(posedge CLK) disable iff (RESET)
		wr && !refuse && PADDR == REG_CTRL |=> RX_FORMAT_SEL == $past(PWDATA[3]))
		else $error("receive format select not taken from the control write");
	a_reset_idle: assert property (@(posedge CLK) disable iff (RESET)
		$fell(RESET) |-> !tx_valid_reg && RX_FORMAT_SEL)
		else $error("not idle with explicit receive after reset");
	a_status_expect: assert property (@(posedge CLK) disable iff (RESET)
		start_ok |=> expect_status_reg == (status_frame_id != 8'h00))
		else $error("status expected flag does not follow the frame id");
endmodule

// ==== etfb_dev_model.sv ====
// behavioural model of the radio module serial port taking frames
`timescale 1ns/1ps
module etfb_dev_model
	import etfb_pkg::*;
#(
	parameter logic [7:0] MAX_HOPS = 8'h1e
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic rx_format_sel
);
	logic [7:0] got[$];
	logic [7:0] len_reg;
	logic [7:0] sum_reg;
	logic [7:0] radius_used;
	logic status_due;
	logic csum_ok;
	logic delim_ok;
	logic explicit_rx;
	int idx;
	////////////////////////////////////////
	// responses come back as explicit frames only when selected
	assign explicit_rx = (rx_format_sel === 1'b1);
	// stall every other cycle when slow
	always @(posedge clk) begin
		if (reset)
			tx_ready <= 1'b1;
		else
			tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	////////////////////////////////////////
	// one byte per accepted transfer
	always @(posedge clk) begin
		if (!reset && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			idx = got.size();
			got.push_back(tx_data);
			if (idx == 0)
				delim_ok <= (tx_data === 8'h7e);
			if (idx == 0)
				sum_reg <= 8'h00;
			if (idx == 2)
				len_reg <= tx_data;
			if (idx == 4)
				status_due <= (tx_data != 8'h00);
			if (idx == 21)
				radius_used <= (tx_data == 8'h00) ? MAX_HOPS : tx_data;
			if (idx >= 3 && idx < 3 + len_reg)
				sum_reg <= sum_reg + tx_data;
			if (idx > 3 && idx == 3 + len_reg)
				csum_ok <= (8'(sum_reg + tx_data) == 8'hff);
		end
	end
endmodule

// ==== etfb_pkg.sv ====
// constants and types shared by the explicit transmit frame builder
package etfb_pkg;
	// frame bytes
	localparam logic [7:0] START_DELIM = 8'h7e;
	localparam logic [7:0] FRAME_TYPE_EXPLICIT = 8'h11;
	localparam logic [7:0] MGMT_ENDPOINT = 8'h00;
	localparam logic [7:0] MGMT_PROFILE_BYTE = 8'h00;
	localparam logic [7:0] TX_OPTIONS_MGMT = 8'h00;
	localparam logic [7:0] CSUM_BASE = 8'hff;
	localparam logic [63:0] DEST64_COORD = 64'h0000000000000000;
	localparam logic [63:0] DEST64_BCAST = 64'h000000000000ffff;
	localparam logic [15:0] DEST16_UNKNOWN = 16'hfffe;
	// frame offsets
	localparam logic [5:0] OFS_LEN_MSB = 6'h01;
	localparam logic [5:0] OFS_LEN_LSB = 6'h02;
	localparam logic [5:0] OFS_TYPE = 6'h03;
	localparam logic [5:0] OFS_FRAME_ID = 6'h04;
	localparam logic [5:0] OFS_DEST64_LSB = 6'h0c;
	localparam logic [5:0] OFS_DEST16_MSB = 6'h0d;
	localparam logic [5:0] OFS_DEST16_LSB = 6'h0e;
	localparam logic [5:0] OFS_SRC_EP = 6'h0f;
	localparam logic [5:0] OFS_DST_EP = 6'h10;
	localparam logic [5:0] OFS_CLUSTER_MSB = 6'h11;
	localparam logic [5:0] OFS_CLUSTER_LSB = 6'h12;
	localparam logic [5:0] OFS_PROFILE_MSB = 6'h13;
	localparam logic [5:0] OFS_PROFILE_LSB = 6'h14;
	localparam logic [5:0] OFS_RADIUS = 6'h15;
	localparam logic [5:0] OFS_OPTIONS = 6'h16;
	localparam logic [5:0] OFS_SEQ = 6'h17;
	localparam logic [5:0] OFS_PARAM = 6'h18;
	localparam logic [7:0] LEN_FIXED = 8'h15;
	localparam logic [3:0] MAX_PARAM_BYTES = 4'h8;
	localparam logic [3:0] ACTIVE_EP_PARAM_BYTES = 4'h2;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DEST_HI = 8'h04;
	localparam logic [7:0] REG_DEST_LO = 8'h08;
	localparam logic [7:0] REG_DEST16 = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_PARAM_LO = 8'h14;
	localparam logic [7:0] REG_PARAM_HI = 8'h18;
	localparam logic [7:0] REG_PLEN = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	// reset values
	localparam logic [2:0] CTRL_RESET = 3'h4;
	localparam logic [31:0] CMD_RESET = 32'h00000000;
	// addressing modes
	localparam logic [1:0] ADDR_UNICAST = 2'h0;
	localparam logic [1:0] ADDR_COORD = 2'h1;
	localparam logic [1:0] ADDR_BCAST = 2'h2;
	// command selectors and their cluster codes
	localparam logic [3:0] CMD_ACTIVE_EP = 4'h4;
	localparam logic [3:0] CMD_LAST = 4'ha;

	function automatic logic [16:0] etfb_cluster(input logic [3:0] sel);
		logic [16:0] r;
		r = 17'h00000;
		unique case (sel)
			4'h0: r = {1'b1, 16'h0000};
			4'h1: r = {1'b1, 16'h0001};
			4'h2: r = {1'b1, 16'h0002};
			4'h3: r = {1'b1, 16'h0004};
			4'h4: r = {1'b1, 16'h0005};
			4'h5: r = {1'b1, 16'h0006};
			4'h6: r = {1'b1, 16'h0031};
			4'h7: r = {1'b1, 16'h0032};
			4'h8: r = {1'b1, 16'h0034};
			4'h9: r = {1'b1, 16'h0036};
			4'ha: r = {1'b1, 16'h0038};
			default: r = 17'h00000;
		endcase
		return r;
	endfunction

	typedef enum logic [0:0] {ETFB_IDLE, ETFB_SEND} etfb_state_t;
endpackage

// ==== tb_top.sv ====
// self-checking bench for the explicit transmit frame builder
`timescale 1ns/1ps
module tb_top
	import etfb_pkg::*;
;
	typedef struct packed {logic [3:0] sel; logic [15:0] cl;} etfb_row_t;
	localparam etfb_row_t ROWS [11] = '{'{4'h0, 16'h0000}, '{4'h1, 16'h0001}, '{4'h2, 16'h0002},
		'{4'h3, 16'h0004}, '{4'h4, 16'h0005}, '{4'h5, 16'h0006}, '{4'h6, 16'h0031}, '{4'h7, 16'h0032},
		'{4'h8, 16'h0034}, '{4'h9, 16'h0036}, '{4'ha, 16'h0038}};
	logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TX_VALID, TX_READY, RX_FORMAT_SEL, slow, rerr;
	logic [7:0] PADDR, TX_DATA;
	logic [31:0] PWDATA, PRDATA, rdat;
	logic [7:0] exp_q[$];
	int bad_count, tests_run, frames;
	etfb_ctrl etfb_ctrl_i (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_FORMAT_SEL(RX_FORMAT_SEL));
	etfb_dev_model etfb_dev_model_i (.clk(CLK), .reset(RESET), .slow(slow), .tx_data(TX_DATA),
		.tx_valid(TX_VALID), .tx_ready(TX_READY), .rx_format_sel(RX_FORMAT_SEL));
	////////////////////////////////////////
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		rdat = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wait_idle();
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
		end while (rdat[0] !== 1'b0);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	// program one command, start it, compare the whole frame
	task automatic send(input etfb_row_t r, input logic [1:0] mode, input logic [3:0] plen, input int i);
		logic [63:0] d64, o64, p64;
		logic [15:0] d16, o16;
		logic [7:0] fid, rad, seq, sum;
		int n;
		d64 = 64'h0102030405060708 + 64'(i);
		d16 = 16'h1234 + 16'(i);
		p64 = 64'h8877665544332211;
		fid = 8'(i);
		rad = (i == 2) ? 8'h00 : 8'(i + 3);
		seq = 8'h40 + 8'(i);
		o64 = (mode == 2'h2) ? 64'h000000000000ffff : (mode == 2'h1) ? 64'h0 : d64;
		o16 = (mode == 2'h2) ? 16'hfffe : d16;
		n = (r.sel == 4'h4) ? 2 : int'(plen);
		etfb_dev_model_i.got.delete();
		apb(1'b1, REG_DEST_HI, d64[63:32]);
		apb(1'b1, REG_DEST_LO, d64[31:0]);
		apb(1'b1, REG_DEST16, {16'h0, d16});
		apb(1'b1, REG_CMD, {seq, rad, fid, 4'h0, r.sel});
		apb(1'b1, REG_PARAM_LO, p64[31:0]);
		apb(1'b1, REG_PARAM_HI, p64[63:32]);
		apb(1'b1, REG_PLEN, {28'h0, plen});
		apb(1'b1, REG_CTRL, {28'h0, 1'b1, mode, 1'b1});
		if (i == 5) begin
			apb(1'b1, REG_CMD, 32'h0);
			chk_bit("write while busy refused", 1'b1, rerr);
		end
		wait_idle();
		frames++;
		exp_q = {8'h7e, 8'h00, 8'(21 + n), 8'h11, fid};
		for (int j = 7; j >= 0; j--)
			exp_q.push_back(o64[j*8 +: 8]);
		exp_q = {exp_q, o16[15:8], o16[7:0], 8'h00, 8'h00, r.cl[15:8], r.cl[7:0], 8'h00, 8'h00, rad, 8'h00, seq};
		for (int j = 0; j < n; j++)
			exp_q.push_back(p64[j*8 +: 8]);
		sum = 8'h00;
		for (int j = 3; j < exp_q.size(); j++)
			sum = sum + exp_q[j];
		exp_q.push_back(8'hff - sum);
		chk_word("frame size", exp_q.size(), etfb_dev_model_i.got.size());
		foreach (exp_q[j])
			chk_word("frame byte", {24'h0, exp_q[j]}, {24'h0, etfb_dev_model_i.got[j]});
		chk_bit("model checksum", 1'b1, etfb_dev_model_i.csum_ok);
		chk_bit("model delimiter", 1'b1, etfb_dev_model_i.delim_ok);
		chk_bit("model status due", fid != 8'h00, etfb_dev_model_i.status_due);
		chk_bit("model explicit receive", 1'b1, etfb_dev_model_i.explicit_rx);
		chk_word("radius used", {24'h0, (rad == 8'h00) ? etfb_dev_model_i.MAX_HOPS : rad},
			{24'h0, etfb_dev_model_i.radius_used});
		apb(1'b0, REG_STATUS, 32'h0);
		chk_bit("status expected", fid != 8'h00, rdat[3]);
		chk_word("frames sent", 32'(frames), {24'h0, rdat[15:8]});
		$display("test frame %0d done", i);
	endtask
	////////////////////////////////////////
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	initial begin
		repeat (30000) @(posedge CLK);
		bad_count++;
		complete_run();
	end
	initial begin
		RESET = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		slow = 1'b0;
		frames = 0;
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		#1;
		chk_bit("tx valid after reset", 1'b0, TX_VALID);
		chk_bit("format select after reset", 1'b1, RX_FORMAT_SEL);
		apb(1'b0, REG_CTRL, 32'h0);
		chk_word("ctrl reset", 32'h4, rdat);
		apb(1'b0, REG_DEST16, 32'h0);
		chk_word("short address reset", 32'h0000fffe, rdat);
		$display("test reset done");
		foreach (ROWS[i]) begin
			slow <= i[0];
			send(ROWS[i], 2'(i % 3), 4'(i % 9), i);
		end
		// invalid selector gives no frame
		etfb_dev_model_i.got.delete();
		apb(1'b1, REG_CMD, 32'h0000010b);
		apb(1'b1, REG_CTRL, 32'h0000000b);
		wait_idle();
		chk_bit("error flag", 1'b1, rdat[2]);
		chk_word("no frame", 32'h0, etfb_dev_model_i.got.size());
		apb(1'b1, REG_CTRL, 32'h0);
		@(negedge CLK);
		chk_bit("format select cleared", 1'b0, RX_FORMAT_SEL);
		apb(1'b0, 8'h24, 32'h0);
		chk_bit("unmapped refused", 1'b1, rerr);
		apb(1'b0, 8'h05, 32'h0);
		chk_bit("unaligned refused", 1'b1, rerr);
		$display("test refusals done");
		complete_run();
	end
endmodule
